//--- rtl/lax_unit.sv
// lax_unit: load address generation and data extension
// assumes: AXI4-Lite master; memory word supplied through a register
//
// The register addresses and the AXI4-Lite interface to the registers are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none
module lax_unit #(
  parameter int NREG = 8
) (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready
);
  localparam int RW = $clog2(NREG);
  localparam int FW = RW + 1;

  // ------------------------------------------------------------
  // bus write channel
  // ------------------------------------------------------------
  logic [7:0]  awaddr_q;
  logic        aw_have_q;
  logic [31:0] wdata_q;
  logic        w_have_q;
  logic        wr_fire;
  logic        wr_map_ok;
  logic [31:0] mode_reg_q;
  logic [31:0] memdata_q;
  logic [31:0] addr_q;
  logic [31:0] result_q;
  logic        busy_q;
  logic        cond_fail_q;
  logic [2:0]  slot_q;
  logic        ld_wr;
  logic        gpr_hit;

  // a bus write to a general register waits out the cycle of a load write-back
  assign ld_wr   = busy_q && slot_q == 3'(lax_pkg::LAX_DELAY_SLOTS);
  assign gpr_hit = awaddr_q >= lax_pkg::LAX_OFS_REG_BASE && awaddr_q < lax_pkg::LAX_OFS_REG_BASE + 8'(8 * NREG)
                && awaddr_q[1:0] == 2'h0;
  assign wr_fire = aw_have_q && w_have_q && !s_axi_bvalid && !(ld_wr && gpr_hit);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_q     <= 1'b0;
      w_have_q      <= 1'b0;
      awaddr_q      <= 8'h00;
      wdata_q       <= 32'h0000_0000;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
    end else begin
      s_axi_awready <= !aw_have_q && !s_axi_awready && !wr_fire;
      s_axi_wready  <= !w_have_q && !s_axi_wready && !wr_fire;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_q <= 1'b1;
        awaddr_q  <= s_axi_awaddr;
      end else if (wr_fire) begin
        aw_have_q <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_q <= 1'b1;
        wdata_q  <= s_axi_wdata;
      end else if (wr_fire) begin
        w_have_q <= 1'b0;
      end
    end
  end

  always_comb begin
    wr_map_ok = (awaddr_q == lax_pkg::LAX_OFS_CMD) || (awaddr_q == lax_pkg::LAX_OFS_MODE_REG)
             || (awaddr_q == lax_pkg::LAX_OFS_MEMDATA)
             || (awaddr_q >= lax_pkg::LAX_OFS_REG_BASE
                 && awaddr_q < lax_pkg::LAX_OFS_REG_BASE + 8'(8 * NREG));
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= lax_pkg::LAX_RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_map_ok ? lax_pkg::LAX_RESP_OKAY : lax_pkg::LAX_RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mode_reg_q <= lax_pkg::LAX_RST_MODE_REG;
      memdata_q  <= 32'h0000_0000;
    end else if (wr_fire) begin
      if (awaddr_q == lax_pkg::LAX_OFS_MODE_REG) begin
        mode_reg_q <= wdata_q;
      end
      if (awaddr_q == lax_pkg::LAX_OFS_MEMDATA) begin
        memdata_q <= wdata_q;
      end
    end
  end

  // ------------------------------------------------------------
  // command decode and address generation
  // ------------------------------------------------------------
  logic        cmd_go;
  logic        c_long;
  logic        c_unit;
  logic [2:0]  c_type;
  logic [3:0]  c_mode;
  logic [2:0]  c_base;
  logic [4:0]  c_ofs;
  logic [14:0] c_cst;
  logic [FW-1:0] base_idx;
  logic [FW-1:0] ofs_idx;
  logic [1:0]  scale;
  logic [31:0] base_v;
  logic [31:0] ofs_v;
  logic [31:0] step;
  logic [31:0] sum;
  logic [31:0] new_base;
  logic [31:0] acc_addr;
  logic        circ;
  logic [4:0]  blk_pow;
  logic [31:0] blk_mask;
  logic [31:0] base_arr [2*NREG];

  assign cmd_go = wr_fire && awaddr_q == lax_pkg::LAX_OFS_CMD && !busy_q;
  assign c_long = wdata_q[lax_pkg::LAX_CMD_LONG];
  assign c_unit = c_long ? 1'b1 : wdata_q[lax_pkg::LAX_CMD_UNIT];
  assign c_type = wdata_q[lax_pkg::LAX_CMD_TYPE_LO +: 3];
  assign c_mode = wdata_q[lax_pkg::LAX_CMD_MODE_LO +: 4];
  assign c_base = wdata_q[lax_pkg::LAX_CMD_BASE_LO +: 3];
  assign c_ofs  = wdata_q[lax_pkg::LAX_CMD_OFS_LO +: 5];
  assign c_cst  = wdata_q[lax_pkg::LAX_CMD_CST_LO +: 15];

  always_comb begin
    // fixed base select in long form, unit side otherwise
    if (c_long) begin
      base_idx = {1'b1, wdata_q[lax_pkg::LAX_CMD_UNIT] ? RW'(lax_pkg::LAX_FIXED_BASE1)
                                                        : RW'(lax_pkg::LAX_FIXED_BASE0)};
    end else begin
      base_idx = {c_unit, RW'(c_base)};
    end
    ofs_idx = {c_unit, RW'(c_ofs)};
    case (c_type)
      lax_pkg::LAX_TYPE_WORD:                         scale = 2'd2;
      lax_pkg::LAX_TYPE_SHALF, lax_pkg::LAX_TYPE_UHALF: scale = 2'd1;
      default:                                        scale = 2'd0;
    endcase
    base_v = base_arr[base_idx];
    if (c_long) begin
      ofs_v = {17'h0_0000, c_cst};
    end else if (c_mode[lax_pkg::LAX_MODE_REGOFS]) begin
      ofs_v = base_arr[ofs_idx];
    end else begin
      ofs_v = {27'h000_0000, c_ofs};
    end
    step = ofs_v << scale;
    sum  = (c_long || c_mode[lax_pkg::LAX_MODE_ADD]) ? base_v + step : base_v - step;
    // circular: mode register holds 2 bits per base 4-7 per file, block size field above
    circ = !c_long && c_base[2]
        && mode_reg_q[{c_unit, c_base[1:0], 1'b0} +: 2] == 2'b01;
    blk_pow  = 5'(mode_reg_q[16 + {c_unit, 2'b00} +: 5] + 5'd1);
    blk_mask = (32'h1 << blk_pow) - 32'h1;
    new_base = circ ? ((base_v & ~blk_mask) | (sum & blk_mask)) : sum;
    acc_addr = (!c_long && c_mode[lax_pkg::LAX_MODE_POST]) ? base_v : new_base;
  end

  // ------------------------------------------------------------
  // register banks, base write-back, result write
  // ------------------------------------------------------------
  logic [2*NREG-1:0][31:0] gpr_q;
  logic [FW-1:0] dst_idx_q;
  logic [2:0]    type_q;
  logic [31:0]   ext_v;
  logic          base_upd;
  logic          rf_we;
  logic [FW-1:0] rf_waddr;
  logic [31:0]   rf_wdata;
  logic [FW-1:0] rf_raddr;
  logic [31:0]   rf_rdata;
  logic [2*NREG-1:0] mir_vld_q;
  logic          mir_hit_q;

  generate
    for (genvar i = 0; i < 2 * NREG; i++) begin : g_regs
      assign base_arr[i] = gpr_q[i];
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          gpr_q[i] <= 32'h0000_0000;
        end else if (wr_fire && awaddr_q == lax_pkg::LAX_OFS_REG_BASE + 8'(4 * i)) begin
          gpr_q[i] <= wdata_q;
        end else if (busy_q && slot_q == 3'(lax_pkg::LAX_DELAY_SLOTS) && dst_idx_q == FW'(i)) begin
          gpr_q[i] <= ext_v;
        end else if (cmd_go && !wdata_q[lax_pkg::LAX_CMD_COND] && !c_long
                     && c_mode[lax_pkg::LAX_MODE_UPD] && base_idx == FW'(i)) begin
          gpr_q[i] <= new_base;
        end
      end
    end
  endgenerate

  always_comb begin
    case (type_q)
      lax_pkg::LAX_TYPE_SBYTE: ext_v = {{24{memdata_q[7]}}, memdata_q[7:0]};
      lax_pkg::LAX_TYPE_UBYTE: ext_v = {24'h00_0000, memdata_q[7:0]};
      lax_pkg::LAX_TYPE_SHALF: ext_v = {{16{memdata_q[15]}}, memdata_q[15:0]};
      lax_pkg::LAX_TYPE_UHALF: ext_v = {16'h0000, memdata_q[15:0]};
      default:                 ext_v = memdata_q;
    endcase
  end

  // bus readback mirror of both banks, written exactly where gpr_q is
  assign base_upd = cmd_go && !wdata_q[lax_pkg::LAX_CMD_COND] && !c_long && c_mode[lax_pkg::LAX_MODE_UPD];
  assign rf_raddr = FW'((s_axi_araddr - lax_pkg::LAX_OFS_REG_BASE) >> 2);

  always_comb begin
    rf_we    = (wr_fire && gpr_hit) || ld_wr || base_upd;
    rf_waddr = base_idx;
    rf_wdata = new_base;
    if (wr_fire && gpr_hit) begin
      rf_waddr = FW'((awaddr_q - lax_pkg::LAX_OFS_REG_BASE) >> 2);
      rf_wdata = wdata_q;
    end else if (ld_wr) begin
      rf_waddr = dst_idx_q;
      rf_wdata = ext_v;
    end
  end

  lax_regfile #(.DEPTH(2 * NREG)) i_gpr_mirror (
    .aclk  (aclk),
    .we    (rf_we),
    .waddr (rf_waddr),
    .wdata (rf_wdata),
    .raddr (rf_raddr),
    .rdata (rf_rdata)
  );

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mir_vld_q <= '0;
      mir_hit_q <= 1'b0;
    end else begin
      mir_hit_q <= mir_vld_q[rf_raddr];
      if (rf_we) begin
        mir_vld_q[rf_waddr] <= 1'b1;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      busy_q      <= 1'b0;
      slot_q      <= 3'd0;
      dst_idx_q   <= '0;
      type_q      <= lax_pkg::LAX_TYPE_WORD;
      addr_q      <= 32'h0000_0000;
      result_q    <= 32'h0000_0000;
      cond_fail_q <= 1'b0;
    end else if (cmd_go) begin
      cond_fail_q <= wdata_q[lax_pkg::LAX_CMD_COND];
      if (!wdata_q[lax_pkg::LAX_CMD_COND]) begin
        busy_q    <= 1'b1;
        slot_q    <= 3'd0;
        addr_q    <= acc_addr;
        type_q    <= c_type;
        dst_idx_q <= {wdata_q[lax_pkg::LAX_CMD_SIDE], RW'(wdata_q[lax_pkg::LAX_CMD_DST_LO +: 3])};
      end
    end else if (busy_q) begin
      if (slot_q == 3'(lax_pkg::LAX_DELAY_SLOTS)) begin
        busy_q   <= 1'b0;
        result_q <= ext_v;
      end else begin
        slot_q <= slot_q + 3'd1;
      end
    end
  end

  // ------------------------------------------------------------
  // bus read channel
  // ------------------------------------------------------------
  logic [31:0] rd_v;
  logic        rd_ok;

  always_comb begin
    rd_ok = 1'b1;
    rd_v  = 32'h0000_0000;
    if (s_axi_araddr == lax_pkg::LAX_OFS_MODE_REG) begin
      rd_v = mode_reg_q;
    end else if (s_axi_araddr == lax_pkg::LAX_OFS_STATUS) begin
      rd_v = {29'h0, cond_fail_q, busy_q, !busy_q};
    end else if (s_axi_araddr == lax_pkg::LAX_OFS_ADDR) begin
      rd_v = addr_q;
    end else if (s_axi_araddr == lax_pkg::LAX_OFS_RESULT) begin
      rd_v = result_q;
    end else if (s_axi_araddr == lax_pkg::LAX_OFS_MEMDATA) begin
      rd_v = memdata_q;
    end else if (s_axi_araddr >= lax_pkg::LAX_OFS_REG_BASE
                 && s_axi_araddr < lax_pkg::LAX_OFS_REG_BASE + 8'(8 * NREG)) begin
      rd_v = mir_hit_q ? rf_rdata : 32'h0000_0000;
    end else if (s_axi_araddr != lax_pkg::LAX_OFS_CMD) begin
      rd_ok = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= lax_pkg::LAX_RESP_OKAY;
    end else begin
      s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rd_v;
        s_axi_rresp  <= rd_ok ? lax_pkg::LAX_RESP_OKAY : lax_pkg::LAX_RESP_SLVERR;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  a_result_slots: assert property (@(posedge aclk) disable iff (!aresetn)
    cmd_go && !wdata_q[lax_pkg::LAX_CMD_COND] |=> busy_q [*5] ##1 !busy_q)
    else $error("load result not written after four delay slots");
  a_fail_idle: assert property (@(posedge aclk) disable iff (!aresetn)
    cmd_go && wdata_q[lax_pkg::LAX_CMD_COND] |=> !busy_q && $stable(addr_q))
    else $error("failed condition started a load");
  a_post_addr: assert property (@(posedge aclk) disable iff (!aresetn)
    cmd_go && !wdata_q[lax_pkg::LAX_CMD_COND] && !c_long && c_mode[lax_pkg::LAX_MODE_POST] |=> addr_q == $past(base_v))
    else $error("post-modify address is not the old base");
  a_long_add: assert property (@(posedge aclk) disable iff (!aresetn)
    cmd_go && !wdata_q[lax_pkg::LAX_CMD_COND] && c_long |=> addr_q == $past(base_v) + ($past(ofs_v) << $past(scale)))
    else $error("long form address not base plus scaled offset");
  a_word_whole: assert property (@(posedge aclk) disable iff (!aresetn)
    ld_wr && type_q == lax_pkg::LAX_TYPE_WORD |=> result_q == $past(memdata_q))
    else $error("word load altered data");
  a_sbyte_sign: assert property (@(posedge aclk) disable iff (!aresetn)
    ld_wr && type_q == lax_pkg::LAX_TYPE_SBYTE |=> result_q[31:8] == {24{$past(memdata_q[7])}})
    else $error("signed byte not sign extended");
  a_uhalf_zero: assert property (@(posedge aclk) disable iff (!aresetn)
    ld_wr && type_q == lax_pkg::LAX_TYPE_UHALF |=> result_q[31:16] == 16'h0000)
    else $error("unsigned half not zero filled");
  a_scale_word: assert property (@(posedge aclk) disable iff (!aresetn)
    cmd_go && c_type == lax_pkg::LAX_TYPE_WORD |-> step == ofs_v << 2)
    else $error("word offset not scaled by four");
endmodule
`default_nettype wire

//--- shared/lax_pkg.sv
// lax_pkg: constants for the load address and extend unit
// assumes: 32-bit core, AXI4-Lite register access, 100 MHz aclk
// Operation
// - address arithmetic is linear; bases 4-7 go circular when mode register says so
// - signed half/byte loads sit low and replicate the sign bit upward
// - unsigned half/byte loads sit low with upper bits cleared
// - word load writes all 32 fetched bits unchanged
// - side-select bit picks destination file, 0 file A, 1 file B
// - load type 010 sbyte, 001 ubyte, 100 shalf, 000 uhalf, 110 word
// - offset shifted left 0, 1 or 2 for byte, half, word
// - mode bits: update base, register offset, post-modify, add
// - base read and written in stage one; loaded value written four slots later
// - long form uses 15-bit unsigned offset, scaled, always added
// - long form base-select 0 first fixed base, 1 second; second unit only
// - long form address arithmetic is always linear
// - pre-modify and offset modes access the sum; post-modify accesses the old base
// - short form unit-select 0 first side file A, 1 second side file B
package lax_pkg;
  // ------------------------------------------------------------
  // register map
  // ------------------------------------------------------------
  localparam logic [7:0]  LAX_OFS_CMD      = 8'h00;
  localparam logic [7:0]  LAX_OFS_MODE_REG = 8'h04;
  localparam logic [7:0]  LAX_OFS_STATUS   = 8'h08;
  localparam logic [7:0]  LAX_OFS_ADDR     = 8'h0C;
  localparam logic [7:0]  LAX_OFS_RESULT   = 8'h10;
  localparam logic [7:0]  LAX_OFS_MEMDATA  = 8'h14;
  localparam logic [7:0]  LAX_OFS_REG_BASE = 8'h80;
  localparam logic [31:0] LAX_RST_MODE_REG = 32'h0000_0000;
  localparam logic [1:0]  LAX_RESP_OKAY    = 2'h0;
  localparam logic [1:0]  LAX_RESP_SLVERR  = 2'h2;
  // ------------------------------------------------------------
  // command word fields
  // ------------------------------------------------------------
  localparam int LAX_CMD_COND    = 0;
  localparam int LAX_CMD_LONG    = 1;
  localparam int LAX_CMD_SIDE    = 2;
  localparam int LAX_CMD_UNIT    = 3;
  localparam int LAX_CMD_TYPE_LO = 4;
  localparam int LAX_CMD_MODE_LO = 7;
  localparam int LAX_CMD_BASE_LO = 11;
  localparam int LAX_CMD_OFS_LO  = 14;
  localparam int LAX_CMD_DST_LO  = 29;
  localparam int LAX_CMD_CST_LO  = 14;
  localparam int LAX_MODE_UPD    = 3;
  localparam int LAX_MODE_REGOFS = 2;
  localparam int LAX_MODE_POST   = 1;
  localparam int LAX_MODE_ADD    = 0;
  // ------------------------------------------------------------
  // load types and timing
  // ------------------------------------------------------------
  localparam logic [2:0] LAX_TYPE_SBYTE = 3'h2;
  localparam logic [2:0] LAX_TYPE_UBYTE = 3'h1;
  localparam logic [2:0] LAX_TYPE_SHALF = 3'h4;
  localparam logic [2:0] LAX_TYPE_UHALF = 3'h0;
  localparam logic [2:0] LAX_TYPE_WORD  = 3'h6;
  localparam int         LAX_DELAY_SLOTS = 4;
  localparam logic [2:0] LAX_FIXED_BASE0 = 3'h6;
  localparam logic [2:0] LAX_FIXED_BASE1 = 3'h7;
endpackage

//--- rtl/lax_regfile.sv
// lax_regfile: two banks of general registers, registered read port
// assumes: single write port, one clock
`timescale 1ns/1ns
`default_nettype none
module lax_regfile #(
  parameter int DEPTH = 8
) (
  input  wire logic                     aclk,
  input  wire logic                     we,
  input  wire logic [$clog2(DEPTH)-1:0] waddr,
  input  wire logic [31:0]              wdata,
  input  wire logic [$clog2(DEPTH)-1:0] raddr,
  output logic      [31:0]              rdata
);
  logic [31:0] mem [DEPTH];

  always_ff @(posedge aclk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata <= mem[raddr];
  end
endmodule
`default_nettype wire

//--- verification/lax_mem_model.sv
// lax_mem_model: data memory answering the load requests of the unit
// assumes: the bench hands it an aligned access address, reads are combinational
`timescale 1ns/1ns
`default_nettype none
module lax_mem_model (
  input  wire logic [31:0] addr,
  output logic      [31:0] word
);
  // --------------------------------------------------------
  // memory contents
  // --------------------------------------------------------
  // sign bits of the low byte and low half are always set
  assign word = {addr[15:0] ^ 16'h3C5A, 8'hC3, addr[7:0] | 8'h80};
endmodule
`default_nettype wire

//--- verification/lax_unit_tb.sv
// lax_unit_tb: register-level tests of the load address and extend unit
// assumes: lax_unit on AXI4-Lite, memory word preloaded from lax_mem_model
`timescale 1ns/1ns
`default_nettype none
module lax_unit_tb;
  localparam logic [2:0] TL [5]  = '{3'h2, 3'h1, 3'h4, 3'h0, 3'h6};
  localparam logic [3:0] ML [12] = '{4'h5, 4'h4, 4'hD, 4'hC, 4'hF, 4'hE, 4'h1, 4'h0, 4'h9, 4'h8, 4'hB, 4'hA};
  logic        aclk          = 1'b0;
  logic        aresetn       = 1'b0;
  logic [7:0]  s_axi_awaddr  = 8'h00;
  logic [7:0]  s_axi_araddr  = 8'h00;
  logic        s_axi_awvalid = 1'b0;
  logic        s_axi_wvalid  = 1'b0;
  logic        s_axi_bready  = 1'b0;
  logic        s_axi_arvalid = 1'b0;
  logic        s_axi_rready  = 1'b0;
  logic [31:0] s_axi_wdata   = 32'h0;
  logic [3:0]  s_axi_wstrb   = 4'hF;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp, r;
  logic [31:0] s_axi_rdata, mem_word, v, a, s, nb;
  logic [31:0] mem_addr      = 32'h0;
  logic [3:0]  m;
  int          n_errors      = 0;
  int          samples_checked = 0;
  always #5 aclk = ~aclk;
  lax_unit #(.NREG(8)) i_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  lax_mem_model i_mem (.addr(mem_addr), .word(mem_word));
  // --------------------------------------------------------
  // checking and closing
  // --------------------------------------------------------
  task automatic finish_test;
    if (n_errors == 0 && samples_checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic check_data(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic check_resp(input logic [1:0] got, input logic [1:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] t=%0t resp got=%h exp=%h", $time, got, exp);
    end
  endtask
  // --------------------------------------------------------
  // bus access
  // --------------------------------------------------------
  task automatic axi_wr(input logic [7:0] ad, input logic [31:0] d, output logic [1:0] rs);
    bit aw, w, b;
    aw = 0;
    w = 0;
    b = 0;
    rs = 2'h3;
    @(posedge aclk);
    s_axi_awaddr <= ad;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!b) begin
      @(posedge aclk);
      if (!aw && s_axi_awready === 1'b1) begin
        aw = 1;
        s_axi_awvalid <= 1'b0;
      end
      if (!w && s_axi_wready === 1'b1) begin
        w = 1;
        s_axi_wvalid <= 1'b0;
      end
      if (s_axi_bvalid === 1'b1) begin
        b = 1;
        rs = s_axi_bresp;
        s_axi_bready <= 1'b0;
      end
    end
  endtask
  task automatic axi_rd(input logic [7:0] ad, output logic [31:0] d, output logic [1:0] rs);
    bit ar, rv;
    ar = 0;
    rv = 0;
    d = 32'h0;
    rs = 2'h3;
    @(posedge aclk);
    s_axi_araddr <= ad;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    while (!rv) begin
      @(posedge aclk);
      if (!ar && s_axi_arready === 1'b1) begin
        ar = 1;
        s_axi_arvalid <= 1'b0;
      end
      if (s_axi_rvalid === 1'b1) begin
        rv = 1;
        d = s_axi_rdata;
        rs = s_axi_rresp;
        s_axi_rready <= 1'b0;
      end
    end
  endtask
  function automatic logic [7:0] gaddr(input logic [3:0] i);
    gaddr = lax_pkg::LAX_OFS_REG_BASE + {2'b00, i, 2'b00};
  endfunction
  // --------------------------------------------------------
  // expectations
  // --------------------------------------------------------
  function automatic logic [31:0] ext(input logic [2:0] t, input logic [31:0] w);
    case (t)
      lax_pkg::LAX_TYPE_SBYTE: ext = {{24{w[7]}}, w[7:0]};
      lax_pkg::LAX_TYPE_UBYTE: ext = {24'h000000, w[7:0]};
      lax_pkg::LAX_TYPE_SHALF: ext = {{16{w[15]}}, w[15:0]};
      lax_pkg::LAX_TYPE_UHALF: ext = {16'h0000, w[15:0]};
      default: ext = w;
    endcase
  endfunction
  function automatic int sh(input logic [2:0] t);
    sh = (t == lax_pkg::LAX_TYPE_WORD) ? 2 : (t == lax_pkg::LAX_TYPE_SHALF || t == lax_pkg::LAX_TYPE_UHALF) ? 1 : 0;
  endfunction
  function automatic logic [31:0] mk(input logic f, input logic lg, input logic sd, input logic un,
                                     input logic [2:0] t, input logic [3:0] md, input logic [2:0] bs,
                                     input logic [14:0] o, input logic [2:0] ds);
    mk = 32'h0;
    mk[lax_pkg::LAX_CMD_COND] = f;
    mk[lax_pkg::LAX_CMD_LONG] = lg;
    mk[lax_pkg::LAX_CMD_SIDE] = sd;
    mk[lax_pkg::LAX_CMD_UNIT] = un;
    mk[lax_pkg::LAX_CMD_TYPE_LO +: 3] = t;
    mk[lax_pkg::LAX_CMD_MODE_LO +: 4] = md;
    mk[lax_pkg::LAX_CMD_BASE_LO +: 3] = bs;
    if (lg) mk[lax_pkg::LAX_CMD_CST_LO +: 15] = o;
    else mk[lax_pkg::LAX_CMD_OFS_LO +: 5] = o[4:0];
    mk[lax_pkg::LAX_CMD_DST_LO +: 3] = ds;
  endfunction
  // one load: preset registers, issue it, then check timing, address and result
  task automatic run_load(input logic [31:0] c, input logic [3:0] bi, input logic [3:0] di, input logic [31:0] bv,
                          input logic [31:0] ea, input logic [31:0] eb, input logic [2:0] t, input logic fl);
    logic [31:0] x;
    logic [1:0]  q;
    mem_addr = ea;
    #1;
    axi_wr(gaddr(bi), bv, q);
    axi_wr(gaddr(di), 32'h5555_AAAA, q);
    axi_wr(lax_pkg::LAX_OFS_MEMDATA, mem_word, q);
    axi_wr(lax_pkg::LAX_OFS_CMD, c, q);
    axi_rd(gaddr(di), x, q);
    check_data(x, 32'h5555_AAAA);
    axi_rd(gaddr(bi), x, q);
    check_data(x, eb);
    repeat (20) begin
      axi_rd(lax_pkg::LAX_OFS_STATUS, x, q);
      if (x[1] === 1'b0) break;
    end
    check_data(x, {29'h0, fl, 2'h1});
    axi_rd(lax_pkg::LAX_OFS_RESULT, x, q);
    if (!fl) check_data(x, ext(t, mem_word));
    axi_rd(lax_pkg::LAX_OFS_ADDR, x, q);
    if (!fl) check_data(x, ea);
    axi_rd(gaddr(di), x, q);
    check_data(x, fl ? 32'h5555_AAAA : ext(t, mem_word));
  endtask
  // --------------------------------------------------------
  // tests
  // --------------------------------------------------------
  initial begin
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    axi_rd(lax_pkg::LAX_OFS_MODE_REG, v, r);
    check_data(v, lax_pkg::LAX_RST_MODE_REG);
    axi_rd(8'hF0, v, r);
    check_resp(r, lax_pkg::LAX_RESP_SLVERR);
    axi_wr(8'hF0, 32'h1, r);
    check_resp(r, lax_pkg::LAX_RESP_SLVERR);
    for (int i = 0; i < 5; i++) begin
      a = 32'h200 + (32'h4 << sh(TL[i]));
      run_load(mk(0, 0, i[0], 0, TL[i], 4'h1, 3'd2, 15'd4, 3'd5), 4'd2, {i[0], 3'd5}, 32'h200, a, 32'h200, TL[i], 0);
    end
    axi_wr(gaddr(4'd11), 32'd5, r);
    for (int i = 0; i < 12; i++) begin
      m = ML[i];
      s = (m[2] ? 32'd20 : 32'd12);
      s = m[0] ? 32'h400 + s : 32'h400 - s;
      a = m[1] ? 32'h400 : s;
      nb = m[3] ? s : 32'h400;
      run_load(mk(0, 0, 0, 1, 3'h6, m, 3'd1, 15'd3, 3'd6), 4'd9, 4'd6, 32'h400, a, nb, 3'h6, 0);
    end
    run_load(mk(0, 0, 1, 0, 3'h0, 4'h9, 3'd3, 15'd1, 3'd1), 4'd3, 4'd9, 32'h300, 32'h302, 32'h302, 3'h0, 0);
    axi_wr(lax_pkg::LAX_OFS_MODE_REG, 32'h0003_0001, r);
    run_load(mk(0, 0, 0, 0, 3'h6, 4'h9, 3'd4, 15'd1, 3'd0), 4'd4, 4'd0, 32'h100C, 32'h1000, 32'h1000, 3'h6, 0);
    run_load(mk(0, 0, 0, 0, 3'h6, 4'h9, 3'd3, 15'd1, 3'd0), 4'd3, 4'd0, 32'h100C, 32'h1010, 32'h1010, 3'h6, 0);
    axi_wr(lax_pkg::LAX_OFS_MODE_REG, 32'h0030_1000, r);
    run_load(mk(0, 1, 0, 0, 3'h4, 4'h0, 3'd0, 15'h7FFF, 3'd7), 4'd14, 4'd7, 32'h2000, 32'h11FFE, 32'h2000, 3'h4, 0);
    run_load(mk(0, 1, 1, 1, 3'h1, 4'h0, 3'd0, 15'h0010, 3'd0), 4'd15, 4'd8, 32'h8000_0000, 32'h8000_0010,
             32'h8000_0000, 3'h1, 0);
    run_load(mk(1, 0, 0, 0, 3'h6, 4'hD, 3'd2, 15'd1, 3'd5), 4'd2, 4'd5, 32'h200, 32'h204, 32'h200, 3'h6, 1);
    finish_test();
  end
  initial begin
    repeat (40000) @(posedge aclk);
    n_errors++;
    finish_test();
  end
endmodule
`default_nettype wire
